/* common/ptws_pkg.sv */
package ptws_pkg;

  // ------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ------------------------------------------------------------
  localparam int unsigned ADDR_W       = 12;
  localparam logic [11:0] IDX_PROT     = 12'hA20;
  localparam logic [11:0] IDX_CTRL     = 12'hA22;
  localparam logic [11:0] IDX_MODULUS  = 12'hA24;
  localparam logic [11:0] IDX_KEY      = 12'hA26;
  localparam logic [11:0] IDX_SOURCE   = 12'hA28;
  localparam logic [11:0] IDX_STATUS   = 12'hA2A;
  localparam logic [11:0] IDX_MASK     = 12'hA2C;

  // ------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------
  localparam logic [10:0] CTRL_RST     = 11'h00F;
  localparam int unsigned CTRL_LVL_LSB = 8;
  localparam int unsigned MOD_PS_BIT   = 8;
  localparam int unsigned PROT_ON_BIT  = 7;
  localparam int unsigned PROT_PS_BIT  = 6;
  localparam int unsigned PROT_RT_LSB  = 4;
  localparam logic        PROT_ON_RST  = 1'b1;
  localparam int unsigned STAT_TICK    = 0;
  localparam int unsigned STAT_WDOG    = 1;
  localparam logic [7:0]  KEY_FIRST    = 8'h55;
  localparam logic [7:0]  KEY_SECOND   = 8'hAA;

  // ------------------------------------------------------------
  // Counts
  // ------------------------------------------------------------
  localparam int unsigned TICK_BASE_DIV = 4;
  localparam logic [4:0]  WD_EXP_STEP   = 5'h02;
  localparam logic [4:0]  WD_EXP_PRESC  = 5'h09;
  localparam logic [4:0]  WD_EXP_FAST   = 5'h07;
  localparam logic [1:0]  STRAP_CYCLES  = 2'h3;

  typedef enum logic [1:0] {SRC_SLOW = 2'b00, SRC_FAST = 2'b01, SRC_EXT = 2'b10} ptws_src_t;
  typedef enum logic {KEY_IDLE = 1'b0, KEY_ARMED = 1'b1} ptws_key_t;
  typedef enum logic {BUS_IDLE = 1'b0, BUS_ANSWER = 1'b1} ptws_bus_t;

endpackage

/* common/ptws_tick_if.sv */
`timescale 1ns/1ns
interface ptws_tick_if;
  logic [7:0] modulus;
  logic       prescale;
  logic       fast;
  logic       tick;
  modport timer (input modulus, input prescale, input fast, output tick);
  modport ctrl  (output modulus, output prescale, output fast, input tick);
endinterface

/* hdl/ptws_tick_timer.sv */
`timescale 1ns/1ns
module ptws_tick_timer
  import ptws_pkg::*;
#(
  parameter int unsigned TICK_PRESCALE = 512,
  parameter int unsigned FAST_FACTOR   = 128
)
(
  input wire logic     core_clk,
  input wire logic     rst_n,
  ptws_tick_if.timer   tif
);

  logic [31:0] div_cnt;
  logic [31:0] div_limit;
  logic [7:0]  count;
  logic        sub_tick;

  // ------------------------------------------------------------
  // Prescaled tick
  // ------------------------------------------------------------
  always_comb
  begin
    div_limit = 32'(TICK_BASE_DIV) * (tif.fast ? 32'(FAST_FACTOR) : 32'h1)
              * (tif.prescale ? 32'(TICK_PRESCALE) : 32'h1);
    // A limit that shrinks below the running count ends the step at once.
    sub_tick  = (div_cnt >= div_limit - 32'h1);
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      div_cnt <= 32'h0;
    else if (count == 8'h0 || sub_tick)
      div_cnt <= 32'h0;
    else
      div_cnt <= div_cnt + 32'h1;
  end

  // ------------------------------------------------------------
  // Modulus down counter
  // ------------------------------------------------------------
  // An idle counter (zero) reloads at once; a new modulus otherwise
  // takes effect at the next reload.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      count <= 8'h0;
    else if (count == 8'h0)
      count <= tif.modulus;
    else if (sub_tick)
      count <= (count == 8'h1) ? tif.modulus : count - 8'h1;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      tif.tick <= 1'b0;
    else
      tif.tick <= sub_tick && (count == 8'h1);
  end

endmodule

/* hdl/ptws_top.sv */
`timescale 1ns/1ns
module ptws_top
  import ptws_pkg::*;
#(
  parameter int unsigned TICK_PRESCALE = 512,
  parameter int unsigned FAST_FACTOR   = 128,
  parameter logic [4:0]  WD_MIN_EXP    = 5'h09
)
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [11:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output      logic [31:0] avs_readdata,
  output      logic        avs_waitrequest,
  input  wire logic        clock_mode_pin,
  input  wire logic        tick_iack,
  output      logic [2:0]  tick_irq_level,
  output      logic [7:0]  tick_vector,
  output      logic        tick_vector_valid,
  output      logic        wd_reset_req,
  output      logic        irq
);

  ptws_tick_if tif ();

  logic        pin_meta;
  logic        pin_sync;
  logic [1:0]  strap_cnt;
  logic        strap_done;
  ptws_bus_t   bus_state;
  logic [15:0] wmask;
  logic [15:0] wdata;
  logic        wr_stb;
  logic [31:0] rd_mux;
  logic [10:0] ctrl;
  logic [7:0]  mod_count;
  logic        mod_ps;
  logic        prot_on;
  logic        prot_ps;
  logic [1:0]  prot_ratio;
  logic        prot_locked;
  ptws_src_t   source;
  logic [1:0]  status;
  logic [1:0]  mask;
  logic [1:0]  events;
  ptws_key_t   key_state;
  logic        key_wr;
  logic        key_ok;
  logic [4:0]  wd_exp;
  logic [31:0] wd_limit;
  logic [31:0] wd_cnt;
  logic        wd_expire;
  logic        tick_pending;

  // ------------------------------------------------------------
  // Mode pin synchroniser and strap capture
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
    end
    else
    begin
      pin_meta <= clock_mode_pin;
      pin_sync <= pin_meta;
    end
  end

  // The bus stays stalled until the synchronised pin level is loaded.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      strap_cnt <= 2'h0;
    else if (strap_cnt != STRAP_CYCLES)
      strap_cnt <= strap_cnt + 2'h1;
  end

  assign strap_done = (strap_cnt == STRAP_CYCLES);

  // ------------------------------------------------------------
  // Avalon-MM slave
  // ------------------------------------------------------------
  // Each request is answered with one wait cycle; the write lands on
  // the edge at which waitrequest is seen low.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bus_state       <= BUS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
    end
    else
    begin
      unique case (bus_state)
        BUS_IDLE:
        begin
          if (strap_done && (avs_read || avs_write))
          begin
            bus_state       <= BUS_ANSWER;
            avs_waitrequest <= 1'b0;
            avs_readdata    <= avs_read ? rd_mux : 32'h0;
          end
        end
        BUS_ANSWER:
        begin
          bus_state       <= BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  assign wr_stb = (bus_state == BUS_ANSWER) && avs_write;
  assign wmask  = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wdata  = avs_writedata[15:0] & wmask;

  always_comb
  begin
    rd_mux = 32'h0;
    unique case (avs_address)
      IDX_PROT:    rd_mux = {24'h0, prot_on, prot_ps, prot_ratio, 4'h0};
      IDX_CTRL:    rd_mux = {21'h0, ctrl};
      IDX_MODULUS: rd_mux = {23'h0, mod_ps, mod_count};
      IDX_KEY:     rd_mux = 32'h0;
      IDX_SOURCE:  rd_mux = {30'h0, source};
      IDX_STATUS:  rd_mux = {30'h0, status};
      IDX_MASK:    rd_mux = {30'h0, mask};
      default:     rd_mux = 32'h0;
    endcase
  end

  // ------------------------------------------------------------
  // Tick control and modulus registers
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      ctrl <= CTRL_RST;
    else if (wr_stb && avs_address == IDX_CTRL)
      ctrl <= (ctrl & ~wmask[10:0]) | wdata[10:0];
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      mod_count <= 8'h0;
    else if (wr_stb && avs_address == IDX_MODULUS && avs_byteenable[0])
      mod_count <= wdata[7:0];
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      mod_ps <= 1'b0;
    else if (strap_cnt == STRAP_CYCLES - 2'h1)
      mod_ps <= pin_sync;
    else if (wr_stb && avs_address == IDX_MODULUS && avs_byteenable[1])
      mod_ps <= wdata[MOD_PS_BIT];
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      source <= SRC_SLOW;
    else if (wr_stb && avs_address == IDX_SOURCE && avs_byteenable[0]
             && wdata[1:0] != 2'b11)
      source <= ptws_src_t'(wdata[1:0]);
  end

  assign tif.modulus  = mod_count;
  assign tif.prescale = mod_ps;
  assign tif.fast     = (source == SRC_FAST);

  ptws_tick_timer #(
    .TICK_PRESCALE (TICK_PRESCALE),
    .FAST_FACTOR   (FAST_FACTOR)
  ) u_timer (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .tif      (tif.timer)
  );

  // ------------------------------------------------------------
  // Tick interrupt request and acknowledge
  // ------------------------------------------------------------
  // A new tick in the acknowledge cycle keeps the request pending.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      tick_pending <= 1'b0;
    else if (ctrl[10:CTRL_LVL_LSB] == 3'h0)
      tick_pending <= 1'b0;
    else if (tif.tick)
      tick_pending <= 1'b1;
    else if (tick_iack && tick_irq_level != 3'h0)
      tick_pending <= 1'b0;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      tick_irq_level <= 3'h0;
    else if (tick_pending && !(tick_iack && tick_irq_level != 3'h0))
      tick_irq_level <= ctrl[10:CTRL_LVL_LSB];
    else
      tick_irq_level <= 3'h0;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tick_vector       <= 8'h0;
      tick_vector_valid <= 1'b0;
    end
    else
    begin
      tick_vector_valid <= tick_iack && tick_irq_level != 3'h0;
      if (tick_iack && tick_irq_level != 3'h0)
        tick_vector <= ctrl[7:0];
    end
  end

  // ------------------------------------------------------------
  // Protection control (writable once after reset)
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prot_on     <= PROT_ON_RST;
      prot_ratio  <= 2'h0;
      prot_locked <= 1'b0;
    end
    else if (wr_stb && avs_address == IDX_PROT && !prot_locked)
    begin
      prot_locked <= 1'b1;
      if (avs_byteenable[0])
      begin
        prot_on    <= wdata[PROT_ON_BIT];
        prot_ratio <= wdata[PROT_RT_LSB +: 2];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      prot_ps <= 1'b0;
    else if (strap_cnt == STRAP_CYCLES - 2'h1)
      prot_ps <= ~pin_sync;
    else if (wr_stb && avs_address == IDX_PROT && !prot_locked && avs_byteenable[0])
      prot_ps <= wdata[PROT_PS_BIT];
  end

  // ------------------------------------------------------------
  // Watchdog key sequence
  // ------------------------------------------------------------
  // Only writes to the key register move the sequence; any other
  // access leaves an armed sequence untouched.
  assign key_wr = wr_stb && avs_address == IDX_KEY && avs_byteenable[0];
  assign key_ok = key_wr && key_state == KEY_ARMED && wdata[7:0] == KEY_SECOND;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      key_state <= KEY_IDLE;
    else if (key_wr)
    begin
      if (wdata[7:0] == KEY_FIRST)
        key_state <= KEY_ARMED;
      else
        key_state <= KEY_IDLE;
    end
  end

  // ------------------------------------------------------------
  // Watchdog counter
  // ------------------------------------------------------------
  always_comb
  begin
    wd_exp = WD_MIN_EXP + (5'(prot_ratio) * WD_EXP_STEP)
           + (prot_ps ? WD_EXP_PRESC : 5'h0)
           + ((source == SRC_FAST) ? WD_EXP_FAST : 5'h0);
    wd_limit  = 32'h1 << wd_exp;
    wd_expire = prot_on && (wd_cnt == wd_limit - 32'h1);
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      wd_cnt <= 32'h0;
    else if (!prot_on || key_ok || wd_expire)
      wd_cnt <= 32'h0;
    else
      wd_cnt <= wd_cnt + 32'h1;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      wd_reset_req <= 1'b0;
    else if (wd_expire)
      wd_reset_req <= 1'b1;
  end

  // ------------------------------------------------------------
  // Event status, mask and interrupt line
  // ------------------------------------------------------------
  assign events = {wd_expire, tif.tick};

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      status <= 2'h0;
    else if (wr_stb && avs_address == IDX_STATUS)
      status <= (status & ~wdata[1:0]) | events;
    else
      status <= status | events;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      mask <= 2'h0;
    else if (wr_stb && avs_address == IDX_MASK && avs_byteenable[0])
      mask <= wdata[1:0];
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= |(status & mask);
  end

endmodule

/* verif/ptws_monitor.sv */
`timescale 1ns/1ns
module ptws_monitor
  import ptws_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic [11:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        tick_iack,
  input wire logic [2:0]  tick_irq_level,
  input wire logic [7:0]  tick_vector,
  input wire logic        tick_vector_valid,
  input wire logic        wd_reset_req
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_ack;
    tick_iack && tick_irq_level != 3'h0;
  endsequence
  sequence s_rd(a);
    avs_read && avs_address == a && !avs_waitrequest;
  endsequence
  property p_one_cycle;
    $fell(avs_waitrequest) |=> avs_waitrequest;
  endproperty
  property p_strap;
    $rose(rst_n) |-> avs_waitrequest [*3];
  endproperty
  property p_ack_vec;
    s_ack |=> tick_vector_valid;
  endproperty
  property p_vec_cause;
    tick_vector_valid |-> $past(tick_iack) && $past(tick_irq_level) != 3'h0;
  endproperty
  property p_vec_hold;
    !tick_vector_valid |-> $stable(tick_vector);
  endproperty
  property p_ctrl_rd;
    s_rd(IDX_CTRL) |-> avs_readdata[31:11] == 21'h000000;
  endproperty
  property p_mod_rd;
    s_rd(IDX_MODULUS) |-> avs_readdata[31:9] == 23'h000000;
  endproperty
  property p_key_rd;
    s_rd(IDX_KEY) |-> avs_readdata == 32'h00000000;
  endproperty
  property p_wd_hold;
    wd_reset_req |=> wd_reset_req;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("answer held too long");
  a_strap: assert property (p_strap) else $error("bus answered during strap");
  a_ack_vec: assert property (p_ack_vec) else $error("no vector after ack");
  a_vec_cause: assert property (p_vec_cause) else $error("vector without ack");
  a_vec_hold: assert property (p_vec_hold) else $error("vector moved");
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("control high bits set");
  a_mod_rd: assert property (p_mod_rd) else $error("modulus high bits set");
  a_key_rd: assert property (p_key_rd) else $error("key read not zero");
  a_wd_hold: assert property (p_wd_hold) else $error("reset request dropped");
endmodule

bind ptws_top ptws_monitor ptws_monitor_i (
  .core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .tick_iack(tick_iack), .tick_irq_level(tick_irq_level), .tick_vector(tick_vector),
  .tick_vector_valid(tick_vector_valid), .wd_reset_req(wd_reset_req)
);

/* verif/ptws_core_model.sv */
`timescale 1ns/1ns
module ptws_core_model
(
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic [2:0] tick_irq_level,
  input  wire logic [7:0] tick_vector,
  input  wire logic       tick_vector_valid,
  input  wire logic [3:0] ack_delay,
  output      logic       tick_iack,
  output      logic [7:0] last_vector,
  output      int         ack_count
);
  logic [3:0] wait_cnt;

  // Acknowledges a pending request after a chosen delay, one pulse per request.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tick_iack   <= 1'b0;
      wait_cnt    <= 4'h0;
      last_vector <= 8'h00;
      ack_count   <= 0;
    end
    else
    begin
      tick_iack <= 1'b0;
      if (tick_vector_valid)
      begin
        last_vector <= tick_vector;
        ack_count   <= ack_count + 1;
      end
      if (tick_irq_level != 3'h0 && !tick_iack)
      begin
        if (wait_cnt == ack_delay)
        begin
          tick_iack <= 1'b1;
          wait_cnt  <= 4'h0;
        end
        else
          wait_cnt <= wait_cnt + 4'h1;
      end
      else
        wait_cnt <= 4'h0;
    end
  end
endmodule

/* verif/tb_top.sv */
`timescale 1ns/1ns
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e); end end
module tb_top;
  import ptws_pkg::*;
  logic        core_clk = 0, rst_n = 0, avs_read = 0, avs_write = 0, clock_mode_pin = 0;
  logic [11:0] avs_address = 12'h000;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [3:0]  avs_byteenable = 4'h0, ack_delay = 4'h1;
  logic        avs_waitrequest, tick_iack, tick_vector_valid, wd_reset_req, irq;
  logic [2:0]  tick_irq_level;
  logic [7:0]  tick_vector, last_vector;
  logic [15:0] q;
  int          ack_count, errors = 0, check_count = 0, cyc = 0, t0, t1, lvl_cnt = 0;

  ptws_top #(.TICK_PRESCALE(4), .FAST_FACTOR(2), .WD_MIN_EXP(5'h06)) ptws_top_i (
    .core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .clock_mode_pin(clock_mode_pin), .tick_iack(tick_iack), .tick_irq_level(tick_irq_level),
    .tick_vector(tick_vector), .tick_vector_valid(tick_vector_valid),
    .wd_reset_req(wd_reset_req), .irq(irq));
  ptws_core_model ptws_core_model_i (
    .core_clk(core_clk), .rst_n(rst_n), .tick_irq_level(tick_irq_level),
    .tick_vector(tick_vector), .tick_vector_valid(tick_vector_valid), .ack_delay(ack_delay),
    .tick_iack(tick_iack), .last_vector(last_vector), .ack_count(ack_count));

  // ----------------------------------------
  // Clock, cycle count and bus tasks
  // ----------------------------------------
  initial forever #20 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;
  always @(posedge core_clk) if (tick_irq_level != 3'h0) lvl_cnt <= lvl_cnt + 1;

  task automatic bus(input logic w, input logic [11:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {16'h0000, d};
    avs_byteenable <= 4'h3;
    do begin @(posedge core_clk); n++; end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) errors++;
    q = avs_readdata[15:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0000);
    `CHK(q, e)
  endtask
  task automatic cwait(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wait_rise(output int t);
    int n;
    n = 0;
    while (tick_irq_level !== 3'h0 && n < 2000) begin @(negedge core_clk); n++; end
    while (tick_irq_level === 3'h0 && n < 2000) begin @(negedge core_clk); n++; end
    if (n >= 2000) errors++;
    t = cyc;
  endtask
  task automatic period(input ptws_src_t s, input logic ps, input logic [7:0] m, input int e);
    wr(IDX_SOURCE, {14'h0000, s});
    wr(IDX_MODULUS, {7'h00, ps, m});
    wait_rise(t0);
    wait_rise(t0);
    wait_rise(t1);
    `CHK(t1 - t0, e)
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    rdchk(IDX_PROT, 16'h00C0);
    rdchk(IDX_CTRL, 16'h000F);
    rdchk(IDX_MODULUS, 16'h0000);
    rdchk(IDX_KEY, 16'h0000);
    rdchk(12'h100, 16'h0000);
    wr(IDX_PROT, 16'h0000);
    wr(IDX_PROT, 16'h00C0);
    rdchk(IDX_PROT, 16'h0000);
    wr(IDX_CTRL, 16'hFFFF);
    rdchk(IDX_CTRL, 16'h07FF);
    wr(IDX_MODULUS, 16'hFE02);
    rdchk(IDX_MODULUS, 16'h0002);
    wr(IDX_KEY, 16'h1234);
    rdchk(IDX_KEY, 16'h0000);
    $display("test regs done");
  endtask
  task automatic t_ticks;
    wr(IDX_CTRL, 16'h003C);
    wr(IDX_STATUS, 16'h0003);
    cwait(2);
    t1 = lvl_cnt;
    cwait(60);
    `CHK(lvl_cnt - t1, 0)
    rdchk(IDX_STATUS, 16'h0001);
    ack_delay <= 4'h5;
    for (int lv = 1; lv < 8; lv++)
    begin
      wr(IDX_CTRL, {5'h00, lv[2:0], 8'h40 + lv[7:0]});
      wait_rise(t0);
      wait_rise(t0);
      `CHK(tick_irq_level, lv[2:0])
      t1 = ack_count;
      while (ack_count == t1 && cyc < t0 + 40) @(negedge core_clk);
      `CHK(last_vector, 8'h40 + lv[7:0])
    end
    ack_delay <= 4'h0;
    period(SRC_SLOW, 1'b0, 8'h05, 20);
    period(SRC_SLOW, 1'b1, 8'h03, 48);
    period(SRC_FAST, 1'b0, 8'h03, 24);
    period(SRC_EXT, 1'b1, 8'h02, 32);
    $display("test ticks done");
  endtask
  task automatic t_irq;
    wr(IDX_MASK, 16'h0001);
    cwait(40);
    `CHK(irq, 1'b1)
    wr(IDX_MASK, 16'h0000);
    cwait(3);
    `CHK(irq, 1'b0)
    wr(IDX_MODULUS, 16'h0000);
    cwait(100);
    wr(IDX_STATUS, 16'h0003);
    rdchk(IDX_STATUS, 16'h0000);
    wr(IDX_MASK, 16'h0001);
    cwait(3);
    `CHK(irq, 1'b0)
    $display("test irq done");
  endtask
  task automatic t_wdog;
    rst_n <= 1'b0;
    clock_mode_pin <= 1'b1;
    cwait(3);
    rst_n <= 1'b1;
    rdchk(IDX_PROT, 16'h0080);
    rdchk(IDX_MODULUS, 16'h0100);
    wr(IDX_PROT, 16'h0090);
    wr(IDX_MASK, 16'h0002);
    repeat (3)
    begin
      cwait(120);
      wr(IDX_KEY, {8'h00, KEY_FIRST});
      rdchk(IDX_CTRL, 16'h000F);
      wr(IDX_KEY, {8'h00, KEY_SECOND});
    end
    t0 = cyc;
    `CHK(wd_reset_req, 1'b0)
    cwait(100);
    wr(IDX_KEY, {8'h00, KEY_FIRST});
    wr(IDX_KEY, 16'h0012);
    wr(IDX_KEY, {8'h00, KEY_SECOND});
    while (cyc < t0 + 240) @(negedge core_clk);
    `CHK(wd_reset_req, 1'b0)
    while (cyc < t0 + 262) @(negedge core_clk);
    `CHK(wd_reset_req, 1'b1)
    `CHK(irq, 1'b1)
    rdchk(IDX_STATUS, 16'h0002);
    $display("test watchdog done");
  endtask

  initial
  begin
    cwait(3);
    rst_n <= 1'b1;
    t_regs;
    t_ticks;
    t_irq;
    t_wdog;
    close_out;
  end
  initial
  begin
    cwait(20000);
    errors++;
    close_out;
  end
endmodule
